// ### asc_pkg.sv
// constants and types shared by the asynchronous static memory controller
`default_nettype none
package asc_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int WORDS = 262144;

  localparam int CLK_PERIOD_NS = 8;
  // slowest speed grade figures, so any grade is met
  localparam int ACCESS_TIME_NS = 15;
  localparam int STROBE_WIDTH_OUTPUTS_ON_NS = 15;
  localparam int OUTPUT_OFF_TIME_NS = 7;
  localparam int ADDRESS_LEAD_TIME_NS = 0;
  localparam int WRITE_RECOVERY_INTERVAL_NS = 0;

  localparam int SYNC_DEPTH = 3;
  localparam int CNT_W = 4;

  // least time as whole cycles, never below one
  function automatic int ns_to_cyc(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACCESS_CYC = ns_to_cyc(ACCESS_TIME_NS);
  localparam int STROBE_CYC = ns_to_cyc(STROBE_WIDTH_OUTPUTS_ON_NS);
  localparam int TURN_CYC = ns_to_cyc(OUTPUT_OFF_TIME_NS);
  localparam int READ_WAIT_CYC = ACCESS_CYC + SYNC_DEPTH;

  localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] READ_LOAD = CNT_W'(READ_WAIT_CYC - 1);

  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [LANES-1:0] LANE_OFF_N = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WSET,
    ST_WPULSE,
    ST_WEND,
    ST_RACC,
    ST_RTURN
  } asc_state_t;

endpackage
`default_nettype wire

// ### asc_rd_if.sv
// carrier for synchronised read data between the pin sampler and controller
`timescale 1ns/1ps
`default_nettype none
interface asc_rd_if;
  import asc_pkg::*;
  logic [DATA_W-1:0] data;
  logic stable;
  modport src (output data, output stable);
  modport dst (input data, input stable);
endinterface
`default_nettype wire

// ### asc_pin_sync.sv
// three-stage sampler for the shared data lines coming back from the memory
`timescale 1ns/1ps
`default_nettype none
module asc_pin_sync
  import asc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [DATA_W-1:0] i_pins,
  asc_rd_if.src rd
);

  logic [DATA_W-1:0] s1_reg;
  logic [DATA_W-1:0] s2_reg;
  logic [DATA_W-1:0] s3_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_reg <= DATA_RST;
      s2_reg <= DATA_RST;
      s3_reg <= DATA_RST;
    end else begin
      s1_reg <= i_pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign rd.data = s3_reg;
  assign rd.stable = (s2_reg == s3_reg);

endmodule
`default_nettype wire

// ### asc_ctrl.sv
// host-side controller driving a 256k x 16 asynchronous static memory
//
// What this block does
// - host must not drive lines while memory drives a read
// - with outputs enabled, host holds strobe low 10/12/15 ns minimum
// - host presents a valid address by the falling edge of select
// - host presents address by start of write, zero set-up allowed
// - host keeps address until write ends; zero recovery interval
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl
  import asc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [LANES-1:0] i_byte_en,
  output logic o_ready,
  output logic o_rvalid,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_wdone,
  output logic o_sel_n,
  output logic o_wstrobe_n,
  output logic o_oe_n,
  output logic o_low_lane_enable_n,
  output logic o_high_lane_enable_n,
  output logic [ADDR_W-1:0] o_word_address,
  output logic [DATA_W-1:0] o_shared_data_lines_out,
  output logic o_shared_data_lines_oe,
  input wire logic [DATA_W-1:0] i_shared_data_lines_in
);

  ////////////////////////////////////////////////////////////////////////////

  asc_rd_if rd ();

  asc_pin_sync u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pins(i_shared_data_lines_in),
    .rd(rd)
  );

  asc_state_t state_reg;
  asc_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [LANES-1:0] be_reg;
  logic accept;
  logic sel_next;
  logic [LANES-1:0] be_use;

  assign accept = (state_reg == ST_IDLE) && i_req;
  assign be_use = accept ? i_byte_en : be_reg;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (i_req) begin
          state_next = i_we ? ST_WSET : ST_RACC;
        end
      end
      ST_WSET: begin
        state_next = ST_WPULSE;
      end
      ST_WPULSE: begin
        if (cnt_reg == '0) begin
          state_next = ST_WEND;
        end
      end
      ST_WEND: begin
        state_next = ST_IDLE;
      end
      ST_RACC: begin
        // wait out access time plus sampler depth, then for settled data
        if (cnt_reg == '0 && rd.stable) begin
          state_next = ST_RTURN;
        end
      end
      ST_RTURN: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      cnt_reg <= (state_next == ST_WPULSE) ? STROBE_LOAD : READ_LOAD;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request capture; address and data only change while deselected

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_word_address <= ADDR_RST;
      o_shared_data_lines_out <= DATA_RST;
      be_reg <= '0;
    end else if (accept) begin
      o_word_address <= i_addr;
      o_shared_data_lines_out <= i_wdata;
      be_reg <= i_byte_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, all registered from the next state

  assign sel_next = (state_next == ST_WSET) || (state_next == ST_WPULSE) ||
                    (state_next == ST_WEND) || (state_next == ST_RACC);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_sel_n <= 1'b1;
      o_wstrobe_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_low_lane_enable_n <= 1'b1;
      o_high_lane_enable_n <= 1'b1;
      o_shared_data_lines_oe <= 1'b0;
    end else begin
      // select falls before the strobe and rises after it, so the strobe
      // alone frames every write
      o_sel_n <= !sel_next;
      o_wstrobe_n <= !(state_next == ST_WPULSE);
      // outputs held off through writes, so the shorter strobe would do
      o_oe_n <= !(state_next == ST_RACC);
      o_low_lane_enable_n <= sel_next ? !be_use[0] : 1'b1;
      o_high_lane_enable_n <= sel_next ? !be_use[1] : 1'b1;
      // lines driven only in write states; the turnaround state covers
      // the memory's output-off time after a read
      o_shared_data_lines_oe <= (state_next == ST_WSET) ||
                                (state_next == ST_WPULSE) ||
                                (state_next == ST_WEND);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user side answers

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ready <= 1'b0;
      o_rvalid <= 1'b0;
      o_wdone <= 1'b0;
      o_rdata <= DATA_RST;
    end else begin
      o_ready <= (state_next == ST_IDLE);
      o_wdone <= (state_reg == ST_WEND);
      o_rvalid <= (state_reg == ST_RACC) && (state_next == ST_RTURN);
      if ((state_reg == ST_RACC) && (state_next == ST_RTURN)) begin
        // lanes left off are forced to zero here, not taken from the pins
        o_rdata <= {be_reg[1] ? rd.data[DATA_W-1:LANE_W] : 8'h00,
                    be_reg[0] ? rd.data[LANE_W-1:0] : 8'h00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_no_contention: assert property (
    !o_sel_n && !o_oe_n |-> !o_shared_data_lines_oe)
    else $error("host drives lines while memory outputs are on");

  a_drive_turnaround: assert property (
    $rose(o_shared_data_lines_oe) |-> $past(o_oe_n, 2))
    else $error("host drives lines too soon after a read");

  a_strobe_width: assert property (
    $fell(o_wstrobe_n) |-> (!o_wstrobe_n)[*2])
    else $error("write strobe shorter than its minimum");

  a_addr_held_select: assert property (
    !o_sel_n && !$past(o_sel_n) |-> $stable(o_word_address))
    else $error("address moved while selected");

  a_addr_at_strobe: assert property (
    $fell(o_wstrobe_n) |-> !o_sel_n && $stable(o_word_address) &&
    o_shared_data_lines_oe)
    else $error("address not settled at start of write");

  a_write_end_hold: assert property (
    $rose(o_wstrobe_n) |-> !o_sel_n && $stable(o_word_address) &&
    $stable(o_shared_data_lines_out))
    else $error("address or data moved at end of write");

  a_oe_off_in_write: assert property (
    !o_wstrobe_n |-> o_oe_n && !o_sel_n)
    else $error("output enable on during write");

  a_read_answer: assert property (
    accept && !i_we |-> ##[5:20] o_rvalid)
    else $error("read answer missing");

  c_write: cover property (accept && i_we ##[1:8] o_wdone);
  c_read: cover property (accept && !i_we ##[1:20] o_rvalid);
  c_byte_write: cover property (!o_wstrobe_n && o_high_lane_enable_n &&
    !o_low_lane_enable_n);
  // a new request can be taken in the very cycle of the write answer
  c_read_after_write: cover property (o_wdone ##[0:4] (accept && !i_we));

endmodule
`default_nettype wire

// ### asc_sram_model.sv
// behavioural 256k x 16 asynchronous static memory seen by the controller
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model
  import asc_pkg::*;
(
  input wire logic i_slow,
  input wire logic i_sel_n,
  input wire logic i_wstrobe_n,
  input wire logic i_oe_n,
  input wire logic i_low_lane_enable_n,
  input wire logic i_high_lane_enable_n,
  input wire logic [ADDR_W-1:0] i_word_address,
  input wire logic [DATA_W-1:0] i_dq,
  input wire logic i_host_drives,
  output logic [DATA_W-1:0] o_dq,
  output int o_clashes
);
  logic [DATA_W-1:0] mem [0:WORDS-1];
  logic [DATA_W-1:0] w, v;
  logic [LANES-1:0] lane_on;
  logic wr_on, rd_on, wr_was, tick;
  ////////////////////////////////////////
  assign lane_on = {~i_high_lane_enable_n, ~i_low_lane_enable_n};
  assign wr_on = ~i_sel_n & ~i_wstrobe_n & (|lane_on);
  assign rd_on = ~i_sel_n & i_wstrobe_n & ~i_oe_n;
  initial begin
    o_clashes = 0;
    wr_was = 0;
    tick = 0;
    // unwritten words read as zero, never unknown
    for (int i = 0; i < WORDS; i++) mem[i] = '0;
  end
  always @(posedge wr_on) wr_was = 1;
  // data is taken when the write ends, not when it starts
  always @(negedge wr_on) begin
    if (wr_was) begin
      w = mem[i_word_address];
      for (int l = 0; l < LANES; l++) begin
        if (lane_on[l]) w[l*8 +: 8] = i_dq[l*8 +: 8];
      end
      mem[i_word_address] = w;
      wr_was = 0;
      tick = ~tick;
    end
  end
  // floating lanes show the inverse so stale data never looks valid
  always @(i_word_address or lane_on or rd_on or tick or i_slow) begin
    w = mem[i_word_address];
    for (int l = 0; l < LANES; l++) begin
      v[l*8 +: 8] = (rd_on & lane_on[l]) ? w[l*8 +: 8] : ~w[l*8 +: 8];
    end
    // slow mode answers at the longest access time the part allows
    o_dq <= #(i_slow ? ACCESS_TIME_NS : 3) v;
  end
  always @(i_host_drives or rd_on or lane_on) begin
    if (i_host_drives & rd_on & (|lane_on)) o_clashes++;
  end
endmodule
`default_nettype wire

// ### asc_ctrl_tb.sv
// self-checking bench for the static memory controller
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_tb;
  import asc_pkg::*;
  logic i_clk, i_srst, i_req, i_we, slow, rdy, rv, wd, sel_n, we_n, oe_n;
  logic lo_n, hi_n, h_oe, sel_d;
  logic [ADDR_W-1:0] i_addr, addr, addr_d;
  logic [DATA_W-1:0] i_wdata, rdata, h_out, m_out;
  logic [LANES-1:0] i_byte_en;
  wire logic [DATA_W-1:0] dq;
  int n_errors, checked, clashes, low_cnt;
  assign dq = h_oe ? h_out : m_out;
  asc_ctrl dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req),
    .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .i_byte_en(i_byte_en),
    .o_ready(rdy), .o_rvalid(rv), .o_rdata(rdata), .o_wdone(wd),
    .o_sel_n(sel_n), .o_wstrobe_n(we_n), .o_oe_n(oe_n),
    .o_low_lane_enable_n(lo_n), .o_high_lane_enable_n(hi_n),
    .o_word_address(addr), .o_shared_data_lines_out(h_out),
    .o_shared_data_lines_oe(h_oe), .i_shared_data_lines_in(dq));
  asc_sram_model mem_u (.i_slow(slow), .i_sel_n(sel_n), .i_wstrobe_n(we_n),
    .i_oe_n(oe_n), .i_low_lane_enable_n(lo_n), .i_high_lane_enable_n(hi_n),
    .i_word_address(addr), .i_dq(dq), .i_host_drives(h_oe),
    .o_dq(m_out), .o_clashes(clashes));
  ////////////////////////////////////////
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic req(input logic we, input logic [17:0] a,
                     input logic [15:0] d, input logic [1:0] be);
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    {i_req, i_we, i_addr, i_wdata, i_byte_en} = {1'b1, we, a, d, be};
    @(negedge i_clk);
    i_req = 0;
    k = 0;
    while ((we ? wd : rv) !== 1'b1 && k < 30) begin
      @(negedge i_clk);
      k++;
    end
    // select lead cycle, the strobe cycles, then the end cycle
    if (we) chk(18'(k), 18'(STROBE_CYC + 2));
    else chk(18'(k >= 5 && k < 30), 18'h1);
  endtask
  task automatic rd(input logic [17:0] a, input logic [1:0] be,
                    input logic [15:0] e);
    req(1'b0, a, 16'h0000, be);
    chk(18'(rdata), 18'(e));
  endtask
  ////////////////////////////////////////
  // the address must hold while selected; strobe must meet the long width
  always @(negedge i_clk) begin
    if (!i_srst && !sel_n && !sel_d) chk(addr, addr_d);
    if (we_n === 1'b0) low_cnt++;
    else if (low_cnt != 0) begin
      chk(18'(low_cnt * CLK_PERIOD_NS >= 15), 18'h1);
      low_cnt = 0;
    end
    sel_d = sel_n;
    addr_d = addr;
  end
  task automatic t_reset;
    chk({17'h0, sel_n}, 18'h1);
    chk({17'h0, h_oe}, 18'h0);
    chk({17'h0, rdy}, 18'h1);
  endtask
  task automatic t_word;
    req(1'b1, 18'h00000, 16'h5aa5, 2'h3);
    req(1'b1, 18'h3ffff, 16'ha55a, 2'h3);
    rd(18'h00000, 2'h3, 16'h5aa5);
    rd(18'h3ffff, 2'h3, 16'ha55a);
  endtask
  task automatic t_lanes;
    req(1'b1, 18'h00100, 16'h1234, 2'h3);
    req(1'b1, 18'h00100, 16'habcd, 2'h1);
    rd(18'h00100, 2'h3, 16'h12cd);
    req(1'b1, 18'h00100, 16'h9876, 2'h2);
    rd(18'h00100, 2'h1, 16'h00cd);
    rd(18'h00100, 2'h2, 16'h9800);
  endtask
  task automatic t_no_lane;
    req(1'b1, 18'h00100, 16'hffff, 2'h0);
    rd(18'h00100, 2'h3, 16'h98cd);
  endtask
  task automatic t_slow;
    slow = 1;
    rd(18'h3ffff, 2'h3, 16'ha55a);
    rd(18'h00000, 2'h3, 16'h5aa5);
    slow = 0;
    chk(18'(clashes), 18'h0);
  endtask
  initial begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    #200000;
    n_errors++;
    results;
  end
  initial begin
    {i_srst, i_req, i_we, i_addr, i_wdata, i_byte_en, slow} = 0;
    {n_errors, checked, low_cnt, sel_d, addr_d} = 0;
    i_srst = 1;
    repeat (5) @(negedge i_clk);
    i_srst = 0;
    @(negedge i_clk);
    t_reset;
    t_word;
    t_lanes;
    t_no_lane;
    t_slow;
    results;
  end
endmodule
`default_nettype wire
